/* logic/tcsi_pkg.sv */
// Constants shared by the touch controller serial command ends.
// Assumes a single 125 MHz system clock on both ends.
package tcsi_pkg;
   // Register indices
   localparam logic [4:0] REG_RATE_SETTLE = 5'h00;
   localparam logic [4:0] REG_SCREEN_FILTER = 5'h01;
   localparam logic [4:0] REG_FILTER_SETTLE = 5'h02;
   localparam logic [4:0] REG_CHANNEL_CODE_MASK = 5'h04;
   localparam logic [4:0] REG_INT_STATUS = 5'h05;
   localparam logic [4:0] REG_SOFT_RESET = 5'h1F;
   // Values after reset, and the soft reset key
   localparam logic [7:0] RST_RATE_SETTLE = 8'h00;
   localparam logic [7:0] RST_SCREEN_FILTER = 8'h20;
   localparam logic [7:0] RST_FILTER_SETTLE = 8'h00;
   localparam logic [7:0] RST_CHANNEL_CODE_MASK = 8'hC0;
   localparam logic [7:0] SOFT_RESET_KEY = 8'hDE;
   // Field positions
   localparam int SETTLE_LSB = 0;
   localparam int MASK_X_BIT = 7;
   localparam int STAT_TOUCH_BIT = 6;
   // Command top bits
   localparam logic [2:0] CMD_WRITE = 3'b000;
   localparam logic [2:0] CMD_READ = 3'b010;
   localparam logic [2:0] CMD_READ_CHANNEL_CODE = 3'b001;
   localparam logic [3:0] CMD_SELECT = 4'b1000;
   localparam logic [3:0] CMD_CONVERT = 4'b1001;
   localparam logic [3:0] CMD_MAN_AUTO = 4'b1011;
   localparam logic [3:0] CMD_TOUCH_DET = 4'b1100;
   localparam logic [3:0] CMD_TOUCH_TRG = 4'b1110;
   // Channel codes
   localparam logic [2:0] CHANNEL_CODE_X = 3'b000;
   localparam logic [2:0] CHANNEL_CODE_AUX = 3'b100;
   localparam logic [2:0] CHANNEL_CODE_SEQ = 3'b111;
   localparam int NUM_CHANNEL_CODE = 5;
   // Data words
   localparam logic [7:0] INVALID_BYTE = 8'hFF;
   localparam logic [15:0] RESULT_MASK = 16'h0FFF;
   // Operating modes
   localparam logic [1:0] MODE_MAN_AUTO = 2'h0;
   localparam logic [1:0] MODE_TOUCH_DET = 2'h1;
   localparam logic [1:0] MODE_TOUCH_TRG = 2'h2;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_BASE_NS = 500;
   localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_NS = 64;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
   localparam int SETTLE_CNT_W = 22;
endpackage : tcsi_pkg

/* logic/tcsi_if.sv */
// Serial link between the host master and the touch controller.
// Assumes the bench resolves the data-out wire from its enable.
`timescale 1ns/1ns
`default_nettype none
interface tcsi_if;
   logic sclk;
   logic chip_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport device (input sclk, input chip_select_n, input mosi, output miso, output miso_oe);
   modport host (output sclk, output chip_select_n, output mosi, input miso, input miso_oe);
endinterface : tcsi_if
`default_nettype wire

/* logic/tcsi_device.sv */
// Touch controller end: serial slave, command decoder, registers, sequencer.
// Assumes an external converter answers each start with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module tcsi_device #(
   parameter int SETTLE_BASE = tcsi_pkg::SETTLE_BASE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   tcsi_if.device link,
   output logic [7:0] rate_settle,
   output logic [7:0] screen_filter,
   output logic [7:0] filter_settle,
   output logic [1:0] op_mode,
   output logic bias_en,
   output logic [2:0] bias_channel,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [11:0] conv_result,
   input wire logic touch_present,
   input wire logic touch_event,
   output logic interrupt_out_n
);
   import tcsi_pkg::*;

   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_SETTLE = 3'b010,
      SQ_CONV = 3'b100
   } tcsi_seq_e;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_WR = 2'h1,
      OP_RD = 2'h2,
      OP_CHANNEL_CODE = 2'h3
   } tcsi_op_e;

   logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2;
   logic [2:0] bit_q, bit_d;
   logic [7:0] rx_q, rx_d, tx_q, tx_d;
   logic load_q, load_d, first_q, first_d, lsb_q, lsb_d;
   tcsi_op_e op_q, op_d;
   logic [4:0] addr_q, addr_d;
   logic [2:0] sel_q, sel_d;
   logic clr_stat_q, clr_stat_d, clr_res_q, clr_res_d;
   logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, mask_q, mask_d;
   logic flag_q, flag_d, srst_q, srst_d;
   logic [1:0] mode_q, mode_d;
   tcsi_seq_e st_q, st_d;
   logic [2:0] cur_q, cur_d, bch_q, bch_d;
   logic [NUM_CHANNEL_CODE-1:0] pend_q, pend_d, val_q, val_d, inv_q, inv_d;
   logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
   logic bias_q, bias_d, start_q, start_d;
   logic [11:0] res_q [NUM_CHANNEL_CODE];
   logic [11:0] res_d [NUM_CHANNEL_CODE];
   logic rise, fall, byte_done, busy, rst;
   logic [7:0] rx_byte, rd_val;
   logic [NUM_CHANNEL_CODE-1:0] mask_en, code_hot;
   logic [2:0] first_val;
   logic any_val;
   logic [SETTLE_CNT_W-1:0] settle_load;

   function automatic logic [2:0] first_one(input logic [NUM_CHANNEL_CODE-1:0] v);
      logic [2:0] r;
      r = CHANNEL_CODE_X;
      for (int i = NUM_CHANNEL_CODE - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : first_one

   // Pin synchronisers; third stage only for edge finding
   always_ff @(posedge clk) begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= link.chip_select_n;
      cs_s2 <= cs_s1;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
   end

   assign rst = !rst_n || srst_q;
   assign rise = sclk_s2 && !sclk_s3 && !cs_s2;
   assign fall = !sclk_s2 && sclk_s3 && !cs_s2;
   assign byte_done = rise && (bit_q == 3'h7);
   assign rx_byte = {rx_q[6:0], mosi_s2};
   assign busy = (st_q != SQ_IDLE);
   assign settle_load = (SETTLE_CNT_W'(SETTLE_BASE) << ctrl0_q[SETTLE_LSB +: 4]) - 1'b1;
   assign first_val = first_one(val_q);
   assign any_val = |val_q;

   // Channel enables from the mask, X in the top bit
   generate
      for (genvar g = 0; g < NUM_CHANNEL_CODE; g++) begin : g_mask
         assign mask_en[g] = mask_q[MASK_X_BIT - g];
         assign code_hot[g] = (rx_byte[2:0] == 3'(g));
      end
   endgenerate

   // Register read mux
   always_comb begin
      case (addr_q)
         REG_RATE_SETTLE: rd_val = ctrl0_q;
         REG_SCREEN_FILTER: rd_val = ctrl1_q;
         REG_FILTER_SETTLE: rd_val = ctrl2_q;
         REG_CHANNEL_CODE_MASK: rd_val = mask_q;
         REG_INT_STATUS: rd_val = 8'(flag_q) << STAT_TOUCH_BIT;
         default: rd_val = 8'h00;
      endcase
   end

   always_comb begin
      bit_d = bit_q;
      rx_d = rx_q;
      tx_d = tx_q;
      load_d = load_q;
      first_d = first_q;
      lsb_d = lsb_q;
      op_d = op_q;
      addr_d = addr_q;
      sel_d = sel_q;
      clr_stat_d = clr_stat_q;
      clr_res_d = clr_res_q;
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      mask_d = mask_q;
      flag_d = flag_q;
      srst_d = 1'b0;
      mode_d = mode_q;
      st_d = st_q;
      cur_d = cur_q;
      bch_d = bch_q;
      pend_d = pend_q;
      val_d = val_q;
      inv_d = inv_q;
      cnt_d = cnt_q;
      bias_d = bias_q;
      start_d = 1'b0;
      res_d = res_q;
      if (cs_s2) begin
         bit_d = 3'h0;
         tx_d = 8'h00;
         load_d = 1'b0;
         first_d = 1'b1;
         lsb_d = 1'b0;
         op_d = OP_NONE;
         clr_stat_d = 1'b0;
         clr_res_d = 1'b0;
      end else begin
         if (rise) begin
            rx_d = rx_byte;
            bit_d = bit_q + 3'h1;
            load_d = byte_done;
         end
         if (byte_done && first_q) begin
            first_d = 1'b0;
            addr_d = rx_byte[4:0];
            if (busy) begin
               op_d = OP_NONE;
            end else if (rx_byte[7:5] == CMD_WRITE) begin
               op_d = OP_WR;
            end else if (rx_byte[7:5] == CMD_READ) begin
               op_d = OP_RD;
            end else if (rx_byte[7:5] == CMD_READ_CHANNEL_CODE) begin
               op_d = OP_CHANNEL_CODE;
            end else begin
               op_d = OP_NONE;
               case (rx_byte[7:4])
                  CMD_SELECT: begin
                     if (rx_byte[2:0] <= CHANNEL_CODE_AUX) begin
                        bias_d = 1'b1;
                        bch_d = rx_byte[2:0];
                     end
                  end
                  CMD_CONVERT: begin
                     if (rx_byte[2:0] == CHANNEL_CODE_SEQ) begin
                        pend_d = mask_en;
                     end else begin
                        pend_d = code_hot;
                     end
                     if (pend_d != '0) begin
                        val_d = '0;
                        cur_d = first_one(pend_d);
                        bch_d = cur_d;
                        bias_d = 1'b1;
                        cnt_d = settle_load;
                        st_d = SQ_SETTLE;
                     end
                  end
                  CMD_MAN_AUTO: mode_d = MODE_MAN_AUTO;
                  CMD_TOUCH_DET: mode_d = MODE_TOUCH_DET;
                  CMD_TOUCH_TRG: mode_d = MODE_TOUCH_TRG;
                  default: op_d = OP_NONE;
               endcase
            end
         end else if (byte_done) begin
            if (op_q == OP_WR) begin
               case (addr_q)
                  REG_RATE_SETTLE: ctrl0_d = rx_byte;
                  REG_SCREEN_FILTER: ctrl1_d = rx_byte;
                  REG_FILTER_SETTLE: ctrl2_d = rx_byte;
                  REG_CHANNEL_CODE_MASK: mask_d = rx_byte;
                  REG_SOFT_RESET: srst_d = (rx_byte == SOFT_RESET_KEY);
                  default: srst_d = 1'b0;
               endcase
               addr_d = addr_q + 5'h01;
            end
            // Side effects of a read land only when the byte was fully sent
            if (clr_stat_q) begin
               flag_d = 1'b0;
            end
            if (clr_res_q) begin
               val_d[sel_q] = 1'b0;
            end
            clr_stat_d = 1'b0;
            clr_res_d = 1'b0;
         end
         if (fall && load_q) begin
            load_d = 1'b0;
            tx_d = 8'h00;
            if (op_q == OP_RD) begin
               tx_d = rd_val;
               clr_stat_d = (addr_q == REG_INT_STATUS);
               addr_d = addr_q + 5'h01;
            end else if (op_q == OP_CHANNEL_CODE) begin
               if (!lsb_q) begin
                  sel_d = first_val;
                  tx_d = (any_val && !inv_q[first_val]) ?
                     {4'h0, res_q[first_val][11:8]} : INVALID_BYTE;
                  lsb_d = 1'b1;
               end else begin
                  tx_d = (val_q[sel_q] && !inv_q[sel_q]) ?
                     res_q[sel_q][7:0] : INVALID_BYTE;
                  clr_res_d = val_q[sel_q];
                  lsb_d = 1'b0;
               end
            end
         end else if (fall) begin
            tx_d = {tx_q[6:0], 1'b0};
         end
      end
      // Touch flag: a new touch wins over the read clear
      if ((mode_q == MODE_TOUCH_DET) && touch_event) begin
         flag_d = 1'b1;
      end
      case (st_q)
         SQ_IDLE: st_d = st_d;
         SQ_SETTLE: begin
            if (cnt_q == '0) begin
               start_d = 1'b1;
               st_d = SQ_CONV;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         SQ_CONV: begin
            if (conv_done) begin
               res_d[cur_q] = conv_result;
               val_d[cur_q] = 1'b1;
               inv_d[cur_q] = !touch_present;
               pend_d[cur_q] = 1'b0;
               bias_d = 1'b0;
               st_d = SQ_IDLE;
               if ((pend_q & ~(NUM_CHANNEL_CODE'(1) << cur_q)) != '0) begin
                  cur_d = first_one(pend_q & ~(NUM_CHANNEL_CODE'(1) << cur_q));
                  bch_d = cur_d;
                  bias_d = 1'b1;
                  cnt_d = settle_load;
                  st_d = SQ_SETTLE;
               end
            end
         end
         default: st_d = SQ_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bit_q <= 3'h0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         load_q <= 1'b0;
         first_q <= 1'b1;
         lsb_q <= 1'b0;
         op_q <= OP_NONE;
         addr_q <= 5'h00;
         sel_q <= CHANNEL_CODE_X;
         clr_stat_q <= 1'b0;
         clr_res_q <= 1'b0;
         ctrl0_q <= RST_RATE_SETTLE;
         ctrl1_q <= RST_SCREEN_FILTER;
         ctrl2_q <= RST_FILTER_SETTLE;
         mask_q <= RST_CHANNEL_CODE_MASK;
         flag_q <= 1'b0;
         srst_q <= 1'b0;
         mode_q <= MODE_MAN_AUTO;
         st_q <= SQ_IDLE;
         cur_q <= CHANNEL_CODE_X;
         bch_q <= CHANNEL_CODE_X;
         pend_q <= '0;
         val_q <= '0;
         inv_q <= '0;
         cnt_q <= '0;
         bias_q <= 1'b0;
         start_q <= 1'b0;
         for (int i = 0; i < NUM_CHANNEL_CODE; i++) begin
            res_q[i] <= 12'h000;
         end
      end else begin
         bit_q <= bit_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         load_q <= load_d;
         first_q <= first_d;
         lsb_q <= lsb_d;
         op_q <= op_d;
         addr_q <= addr_d;
         sel_q <= sel_d;
         clr_stat_q <= clr_stat_d;
         clr_res_q <= clr_res_d;
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         mask_q <= mask_d;
         flag_q <= flag_d;
         srst_q <= srst_d;
         mode_q <= mode_d;
         st_q <= st_d;
         cur_q <= cur_d;
         bch_q <= bch_d;
         pend_q <= pend_d;
         val_q <= val_d;
         inv_q <= inv_d;
         cnt_q <= cnt_d;
         bias_q <= bias_d;
         start_q <= start_d;
         res_q <= res_d;
      end
   end

   assign link.miso = tx_q[7];
   assign link.miso_oe = !cs_s2;
   assign rate_settle = ctrl0_q;
   assign screen_filter = ctrl1_q;
   assign filter_settle = ctrl2_q;
   assign op_mode = mode_q;
   assign bias_en = bias_q;
   assign bias_channel = bch_q;
   assign conv_start = start_q;
   assign interrupt_out_n = !flag_q;
endmodule : tcsi_device
`default_nettype wire

/* logic/tcsi_host.sv */
// Host end: serial master sending one byte per user request.
// Assumes the user marks the last byte of each operation.
`timescale 1ns/1ns
`default_nettype none
module tcsi_host (
   input wire logic clk,
   input wire logic rst_n,
   tcsi_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_last,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   import tcsi_pkg::*;

   typedef enum logic [4:0] {
      HS_IDLE = 5'b00001,
      HS_LOW = 5'b00010,
      HS_HIGH = 5'b00100,
      HS_NEXT = 5'b01000,
      HS_END = 5'b10000
   } tcsi_hst_e;

   localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

   tcsi_hst_e st_q, st_d;
   logic [3:0] div_q, div_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] tx_q, tx_d, rx_q, rx_d, out_q, out_d;
   logic last_q, last_d, sclk_q, sclk_d, cs_n_q, cs_n_d, rxv_q, rxv_d;
   logic miso_s1, miso_s2;
   logic tick;

   always_ff @(posedge clk) begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
   end

   assign tick = (div_q == HALF_LAST);
   assign cmd_ready = (st_q == HS_IDLE) || (st_q == HS_NEXT);

   always_comb begin
      st_d = st_q;
      div_d = tick ? 4'h0 : div_q + 4'h1;
      bit_d = bit_q;
      tx_d = tx_q;
      rx_d = rx_q;
      out_d = out_q;
      last_d = last_q;
      sclk_d = sclk_q;
      cs_n_d = cs_n_q;
      rxv_d = 1'b0;
      case (st_q)
         HS_IDLE, HS_NEXT: begin
            div_d = 4'h0;
            if (cmd_valid) begin
               tx_d = cmd_byte;
               last_d = cmd_last;
               bit_d = 3'h0;
               cs_n_d = 1'b0;
               st_d = HS_LOW;
            end
         end
         HS_LOW: begin
            if (tick) begin
               sclk_d = 1'b1;
               rx_d = {rx_q[6:0], miso_s2};
               st_d = HS_HIGH;
            end
         end
         HS_HIGH: begin
            if (tick) begin
               sclk_d = 1'b0;
               tx_d = {tx_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               st_d = HS_LOW;
               if (bit_q == 3'h7) begin
                  out_d = rx_q;
                  rxv_d = 1'b1;
                  st_d = last_q ? HS_END : HS_NEXT;
                  cs_n_d = last_q;
               end
            end
         end
         HS_END: begin
            if (tick) begin
               st_d = HS_IDLE;
            end
         end
         default: st_d = HS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= HS_IDLE;
         div_q <= 4'h0;
         bit_q <= 3'h0;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         out_q <= 8'h00;
         last_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         rxv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         bit_q <= bit_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         out_q <= out_d;
         last_q <= last_d;
         sclk_q <= sclk_d;
         cs_n_q <= cs_n_d;
         rxv_q <= rxv_d;
      end
   end

   assign link.sclk = sclk_q;
   assign link.chip_select_n = cs_n_q;
   assign link.mosi = tx_q[7];
   assign rx_valid = rxv_q;
   assign rx_byte = out_q;
endmodule : tcsi_host
`default_nettype wire

/* dv/tcsi_monitor.sv */
// Checker on the serial link between host end and device end.
// Assumes the link signals and the common system clock and reset.
`timescale 1ns/1ns
`default_nettype none
module tcsi_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   import tcsi_pkg::*;
   logic sclk_q;
   logic sclk_d;
   logic [2:0] rise_cnt_q;
   logic [2:0] rise_cnt_d;
   always_comb begin
      sclk_d = sclk;
      rise_cnt_d = (!rst_n || chip_select_n) ? 3'h0 : rise_cnt_q + {2'h0, sclk & ~sclk_q};
   end
   always_ff @(posedge clk) begin
      sclk_q <= sclk_d;
      rise_cnt_q <= rise_cnt_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_sclk_idle_low: assert property (chip_select_n |-> !sclk)
      else $error("sclk high outside a frame");
   a_select_clk_low: assert property ($fell(chip_select_n) |-> !sclk [*8] ##1 sclk)
      else $error("sclk not low for 8 cycles after select");
   a_high_phase: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("sclk high phase not 8 cycles");
   a_low_phase: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("sclk low phase too short");
   a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while sclk high");
   a_miso_steady: assert property (sclk && $past(sclk) && miso_oe && $past(miso_oe)
      |-> $stable(miso))
      else $error("miso moved while sclk high");
   a_whole_bytes: assert property ($rose(chip_select_n) |-> rise_cnt_q == 3'h0)
      else $error("frame not a whole number of bytes");
   a_gap_between: assert property ($rose(chip_select_n) |-> chip_select_n [*8])
      else $error("select gap between frames too short");
   a_oe_release: assert property (chip_select_n [*6] |-> !miso_oe)
      else $error("miso driven without select");
   c_frame_end: cover property ($rose(chip_select_n));
   c_oe_on: cover property ($rose(miso_oe));
   c_miso_one: cover property (miso_oe && miso && sclk);
endmodule : tcsi_monitor
`default_nettype wire

/* dv/test_touch_spi_command_interface.sv */
// Bench joining host end and device end over the serial link.
// Assumes a converter stub and a touch source driven from here.
`timescale 1ns/1ns
`default_nettype none
module test_touch_spi_command_interface;
   import tcsi_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_last = 1'b0;
   logic [7:0] cmd_byte = 8'h00;
   logic conv_done = 1'b0;
   logic [11:0] conv_result = 12'h000;
   logic touch_present = 1'b0;
   logic touch_event = 1'b0;
   logic cmd_ready, rx_valid, bias_en, conv_start, interrupt_out_n;
   logic [7:0] rx_byte, rate_settle, screen_filter, filter_settle;
   logic [1:0] op_mode;
   logic [2:0] bias_channel;
   int err_total = 0;
   int cmp_count = 0;
   int dly = 0;
   int gap = 0;
   int gaps[$];
   localparam int BENCH_SETTLE = 2;
   logic [2:0] seen[$];
   logic [7:0] rq[$];
   logic [7:0] rstv[$] = {RST_RATE_SETTLE, RST_SCREEN_FILTER, RST_FILTER_SETTLE, 8'h00,
      RST_CHANNEL_CODE_MASK, 8'h00};
   always #4 clk = ~clk;
   tcsi_if link();
   tcsi_device #(.SETTLE_BASE(BENCH_SETTLE)) u_tcsi_device (.clk(clk), .rst_n(rst_n), .link(link),
      .rate_settle(rate_settle), .screen_filter(screen_filter), .filter_settle(filter_settle),
      .op_mode(op_mode), .bias_en(bias_en), .bias_channel(bias_channel),
      .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
      .touch_present(touch_present), .touch_event(touch_event),
      .interrupt_out_n(interrupt_out_n));
   tcsi_host u_tcsi_host (.clk(clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .cmd_last(cmd_last), .rx_valid(rx_valid),
      .rx_byte(rx_byte));
   tcsi_monitor u_tcsi_monitor (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
      .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso),
      .miso_oe(link.miso_oe));
   // Converter stub: result 0x111 times (code + 1), done 4 cycles after start
   // Also counts settle cycles from bias on or from the last done
   always @(posedge clk) begin
      conv_done <= (dly == 1);
      if (dly == 1) begin
         conv_result <= 12'h111 * {9'h000, bias_channel} + 12'h111;
      end
      dly <= (conv_start === 1'b1) ? 4 : ((dly != 0) ? dly - 1 : 0);
      gap <= (bias_en !== 1'b1 || conv_done === 1'b1) ? 0 : gap + 1;
      if (conv_start === 1'b1) begin
         seen.push_back(bias_channel);
         gaps.push_back(gap);
      end
   end
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic tmo;
      err_total++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop;
   endtask : tmo
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r);
      int i;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      cmd_last <= last;
      for (i = 0; i < 50; i++) begin
         @(negedge clk);
         if (cmd_ready === 1'b1) break;
      end
      if (i == 50) tmo;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (rx_valid === 1'b1) break;
      end
      if (i == 400) tmo;
      r = rx_byte;
   endtask : xfer
   task automatic frame(input logic [7:0] b[$]);
      logic [7:0] r;
      rq = {};
      foreach (b[i]) begin
         xfer(b[i], i == b.size() - 1, r);
         rq.push_back(r);
      end
   endtask : frame
   task automatic rd(input logic [4:0] a, input logic [7:0] e[$]);
      logic [7:0] b[$];
      b.push_back({3'b010, a});
      foreach (e[i]) b.push_back(8'h00);
      frame(b);
      foreach (e[i]) chk(rq[i + 1], e[i]);
   endtask : rd
   task automatic pulse_touch;
      @(posedge clk);
      touch_event <= !touch_event;
      @(posedge clk);
      touch_event <= !touch_event;
      repeat (6) @(posedge clk);
   endtask : pulse_touch
   task automatic run(input logic [7:0] cmd, input logic [4:0] set, input logic tp,
      input logic busy);
      int i;
      logic [7:0] e[$];
      logic [7:0] b[$];
      logic [7:0] ch[$];
      @(posedge clk);
      touch_present <= tp;
      seen = {};
      gaps = {};
      frame({cmd});
      if (busy) frame({8'h01, 8'h99});
      for (i = 0; i < 5000; i++) begin
         @(negedge clk);
         if (seen.size() == $countones(set) && bias_en === 1'b0 && dly == 0) break;
      end
      if (i == 5000) tmo;
      if (busy) rd(5'h01, {8'h5A});
      for (int c = 0; c < 5; c++) begin
         if (set[4 - c]) begin
            ch.push_back(8'(c));
            e.push_back(tp ? 8'(c + 1) : 8'hFF);
            e.push_back(tp ? 8'(8'h11 * (c + 1)) : 8'hFF);
         end
      end
      e.push_back(8'hFF);
      e.push_back(8'hFF);
      b.push_back(8'h20);
      foreach (e[j]) b.push_back(8'h00);
      frame(b);
      foreach (ch[j]) chk({5'h00, seen[j]}, ch[j]);
      foreach (gaps[j]) begin
         if (!busy || j > 0) chk(8'(gaps[j]), 8'(BENCH_SETTLE << 6));
      end
      foreach (e[j]) chk(rq[j + 1], e[j]);
      frame({8'h3F, 8'h00, 8'h00});
      chk(rq[1], 8'hFF);
      chk(rq[2], 8'hFF);
   endtask : run
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(5'h00, rstv);
      rd(5'h1F, {8'h00});
      $display("test reset_values ended");
      frame({8'h00, 8'h06, 8'h5A, 8'h33, 8'h77, 8'hF8, 8'h44});
      rd(5'h00, {8'h06, 8'h5A, 8'h33, 8'h00, 8'hF8, 8'h00});
      chk(rate_settle, 8'h06);
      chk(filter_settle, 8'h33);
      $display("test register_write ended");
      seen = {};
      frame({8'h83});
      chk({7'h00, bias_en}, 8'h01);
      frame({8'h95});
      frame({8'h8E});
      repeat (100) @(posedge clk);
      chk({5'h00, bias_channel}, 8'h03);
      chk(8'(seen.size()), 8'h00);
      $display("test select_reserved ended");
      run(8'h97, 5'h1F, 1'b1, 1'b1);
      frame({8'h04, 8'hC8});
      run(8'h9F, 5'h19, 1'b1, 1'b0);
      for (int c = 0; c < 5; c++) run(8'h98 + 8'(c), 5'h10 >> c, c != 4, 1'b0);
      $display("test conversions ended");
      frame({8'hC5});
      chk({6'h00, op_mode}, 8'h01);
      pulse_touch;
      chk({7'h00, interrupt_out_n}, 8'h00);
      rd(5'h05, {8'h40});
      repeat (4) @(posedge clk);
      chk({7'h00, interrupt_out_n}, 8'h01);
      rd(5'h05, {8'h00});
      frame({8'hE3});
      chk({6'h00, op_mode}, 8'h02);
      frame({8'hB7});
      chk({6'h00, op_mode}, 8'h00);
      pulse_touch;
      chk({7'h00, interrupt_out_n}, 8'h01);
      $display("test modes_touch ended");
      frame({8'hC0});
      frame({8'h1F, 8'h55});
      rd(5'h00, {8'h06});
      frame({8'h1F, 8'hDE});
      repeat (10) @(posedge clk);
      rd(5'h00, rstv);
      chk({6'h00, op_mode}, 8'h00);
      chk(screen_filter, 8'h20);
      $display("test soft_reset ended");
      report_and_stop;
   end
endmodule : test_touch_spi_command_interface
`default_nettype wire
